// ==== uart_irq_pkg.sv ====
package uart_irq_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address on the bus is four times the index.
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_INT_ENABLE = 8'hC1;
	localparam logic [7:0] IDX_IDENT_FCTL = 8'hC2;
	localparam logic [7:0] IDX_MODEM_CONTROL = 8'hC4;
	localparam logic [7:0] IDX_LINE_STATUS = 8'hC5;
	localparam logic [7:0] IDX_MODEM_STATUS = 8'hC6;
	localparam logic [7:0] IDX_EVENT_STATUS = 8'hC8;
	localparam logic [7:0] IDX_EVENT_CLEAR = 8'hC9;
	localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = {2'h0, IDX_INT_ENABLE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IDENT_FCTL = {2'h0, IDX_IDENT_FCTL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_MODEM_CONTROL = {2'h0, IDX_MODEM_CONTROL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LINE_STATUS = {2'h0, IDX_LINE_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_MODEM_STATUS = {2'h0, IDX_MODEM_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = {2'h0, IDX_EVENT_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_EVENT_CLEAR = {2'h0, IDX_EVENT_CLEAR, 2'h0};

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt source bits, shared by enable, status and clear registers.
	localparam int EV_W = 5;
	localparam int EV_RX = 0;
	localparam int EV_TX_EMPTY = 1;
	localparam int EV_LINE = 2;
	localparam int EV_MODEM = 3;
	localparam int EV_TX_DONE = 4;

	// Modem control bits.
	localparam int MC_W = 5;
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_USER_OUTPUT_ONE = 2;
	localparam int MC_USER_OUTPUT_TWO = 3;
	localparam int MC_LOOP = 4;

	// Modem status change flag bits in the low nibble.
	localparam int MS_CTS_CHG = 0;
	localparam int MS_DSR_CHG = 1;
	localparam int MS_RI_TRAIL = 2;
	localparam int MS_DCD_CHG = 3;

	// Line status bits.
	localparam int LS_DATA_READY = 0;
	localparam int LS_ERR_LO = 1;
	localparam int LS_THR_EMPTY = 5;
	localparam int LS_TX_IDLE = 6;
	localparam int LS_FIFO_ERR = 7;

	// FIFO control and identification fields.
	localparam int FC_FIFO_EN = 0;
	localparam int II_NONE = 0;
	localparam int II_CODE_LO = 1;
	localparam int II_FIFO_ON = 7;
	localparam logic [2:0] CODE_LINE = 3'h3;
	localparam logic [2:0] CODE_RX = 3'h2;
	localparam logic [2:0] CODE_TIMEOUT = 3'h6;
	localparam logic [2:0] CODE_TX_EMPTY = 3'h1;
	localparam logic [2:0] CODE_TX_DONE = 3'h4;
	localparam logic [2:0] CODE_MODEM = 3'h0;

	// Reset values.
	localparam logic [EV_W-1:0] INT_ENABLE_RST = 5'h00;
	localparam logic [MC_W-1:0] MODEM_CONTROL_RST = 5'h00;
	localparam logic [7:0] IDENT_RST = 8'h01;

	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		BUS_IDLE = 3'h1,
		BUS_LATCH = 3'h2,
		BUS_DONE = 3'h4
	} bus_state_t;

	// Modem input pins, active low, ordered as the status nibble.
	typedef struct packed {
		logic dcd_n;
		logic ri_n;
		logic dsr_n;
		logic cts_n;
	} modem_pins_t;

	typedef struct packed {
		logic dtr_n;
		logic rts_n;
		logic user_output_one;
		logic user_output_two;
	} modem_drive_t;

	// Status from the receiver and transmitter around this block.
	typedef struct packed {
		logic rx_data_ready;
		logic rx_timeout;
		logic rx_fifo_err;
		logic tx_holding_empty;
		logic tx_shift_empty;
		logic parity_err;
		logic framing_err;
		logic overrun_err;
		logic break_seen;
	} core_status_t;

endpackage : uart_irq_pkg

// ==== modem_edge_detect.sv ====
module modem_edge_detect
	import uart_irq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] level,
	output logic [3:0] change,
	output logic [3:0] fall
);

	typedef struct packed {
		logic [3:0] prev;
		logic primed;
	} edge_state_t;

	edge_state_t s_q;
	edge_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.prev = level;
		s_d.primed = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// The first cycle after reset holds no valid history, so no edge is reported then.
	for (genvar i = 0; i < 4; i++) begin : g_bit
		assign change[i] = s_q.primed & (s_q.prev[i] ^ level[i]);
		assign fall[i] = s_q.primed & s_q.prev[i] & ~level[i];
	end

endmodule : modem_edge_detect

// ==== uart_irq_modem_status.sv ====
module uart_irq_modem_status
	import uart_irq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire modem_pins_t modem_pins,
	output modem_drive_t modem_drive,
	input wire core_status_t core_status,
	output logic fifo_on_status,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// State.
	typedef struct packed {
		bus_state_t bus;
		logic [31:0] rdata;
		logic slverr;
		logic [EV_W-1:0] int_enable;
		logic fifo_on;
		logic [MC_W-1:0] modem_control;
		logic [3:0] line_err;
		logic [3:0] modem_flags;
		logic [EV_W-1:0] ev_status;
		modem_drive_t drive;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic [3:0] modem_level;
	logic [3:0] modem_change;
	logic [3:0] modem_fall;
	logic [3:0] flag_set;
	logic [3:0] line_err_set;
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] pending;
	logic [7:0] ident_value;
	logic [7:0] modem_status_value;
	logic [7:0] line_status_value;
	logic [31:0] read_value;
	logic addr_hit;
	logic access_start;
	logic access_end;
	logic rd_modem_status;
	logic rd_line_status;
	logic wr_ok;

	////////////////////////////////////////////////////////////////////////////////
	// Modem status inputs: inverted pins in normal mode, looped back outputs otherwise.
	always_comb begin
		if (s_q.modem_control[MC_LOOP]) begin
			modem_level[3] = s_q.modem_control[MC_USER_OUTPUT_TWO];
			modem_level[2] = s_q.modem_control[MC_USER_OUTPUT_ONE];
			modem_level[1] = s_q.modem_control[MC_DTR];
			modem_level[0] = s_q.modem_control[MC_RTS];
		end else begin
			modem_level[3] = ~modem_pins.dcd_n;
			modem_level[2] = ~modem_pins.ri_n;
			modem_level[1] = ~modem_pins.dsr_n;
			modem_level[0] = ~modem_pins.cts_n;
		end
	end

	modem_edge_detect u_edges (
		.pclk(pclk),
		.presetn(presetn),
		.level(modem_level),
		.change(modem_change),
		.fall(modem_fall)
	);

	// A trailing ring edge is the status bit falling, that is the active-low pin releasing.
	always_comb begin
		flag_set = '0;
		flag_set[MS_DCD_CHG] = modem_change[3];
		flag_set[MS_RI_TRAIL] = modem_fall[2];
		flag_set[MS_DSR_CHG] = modem_change[1];
		flag_set[MS_CTS_CHG] = modem_change[0];
	end

	assign line_err_set = {core_status.break_seen, core_status.framing_err,
		core_status.parity_err, core_status.overrun_err};

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt sources; level causes keep setting their bit while they last.
	always_comb begin
		ev_set = '0;
		ev_set[EV_RX] = core_status.rx_data_ready | core_status.rx_timeout;
		ev_set[EV_TX_EMPTY] = core_status.tx_holding_empty;
		ev_set[EV_LINE] = |line_err_set;
		ev_set[EV_MODEM] = |flag_set;
		ev_set[EV_TX_DONE] = core_status.tx_holding_empty & core_status.tx_shift_empty;
	end

	// Only enabled sources reach the output and the identification code.
	assign pending = s_q.ev_status & s_q.int_enable;
	assign irq = |pending;

	////////////////////////////////////////////////////////////////////////////////
	// Read values.
	always_comb begin
		ident_value = IDENT_RST;
		ident_value[II_FIFO_ON] = s_q.fifo_on;
		if (pending[EV_LINE]) begin
			ident_value[II_CODE_LO +: 3] = CODE_LINE;
			ident_value[II_NONE] = 1'b0;
		end else if (pending[EV_RX]) begin
			ident_value[II_CODE_LO +: 3] = core_status.rx_timeout ? CODE_TIMEOUT : CODE_RX;
			ident_value[II_NONE] = 1'b0;
		end else if (pending[EV_TX_EMPTY]) begin
			ident_value[II_CODE_LO +: 3] = CODE_TX_EMPTY;
			ident_value[II_NONE] = 1'b0;
		end else if (pending[EV_TX_DONE]) begin
			ident_value[II_CODE_LO +: 3] = CODE_TX_DONE;
			ident_value[II_NONE] = 1'b0;
		end else if (pending[EV_MODEM]) begin
			ident_value[II_CODE_LO +: 3] = CODE_MODEM;
			ident_value[II_NONE] = 1'b0;
		end
	end

	assign modem_status_value = {modem_level, s_q.modem_flags};

	always_comb begin
		line_status_value = '0;
		line_status_value[LS_DATA_READY] = core_status.rx_data_ready;
		line_status_value[LS_ERR_LO +: 4] = s_q.line_err;
		line_status_value[LS_THR_EMPTY] = core_status.tx_holding_empty;
		line_status_value[LS_TX_IDLE] = core_status.tx_holding_empty & core_status.tx_shift_empty;
		line_status_value[LS_FIFO_ERR] = core_status.rx_fifo_err;
	end

	always_comb begin
		read_value = '0;
		addr_hit = 1'b1;
		case (paddr)
			ADDR_INT_ENABLE: begin
				read_value[EV_W-1:0] = s_q.int_enable;
			end
			ADDR_IDENT_FCTL: begin
				read_value[7:0] = ident_value;
			end
			ADDR_MODEM_CONTROL: begin
				read_value[MC_W-1:0] = s_q.modem_control;
			end
			ADDR_LINE_STATUS: begin
				read_value[7:0] = line_status_value;
			end
			ADDR_MODEM_STATUS: begin
				read_value[7:0] = modem_status_value;
			end
			ADDR_EVENT_STATUS: begin
				read_value[EV_W-1:0] = s_q.ev_status;
			end
			ADDR_EVENT_CLEAR: begin
				read_value = '0;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus sequencing: two wait states, the answer and every side effect at the final edge.
	assign access_start = psel & penable & (s_q.bus == BUS_IDLE);
	assign access_end = psel & penable & (s_q.bus == BUS_DONE);
	assign wr_ok = access_end & pwrite & ~s_q.slverr;
	assign rd_modem_status = access_end & ~pwrite & (paddr == ADDR_MODEM_STATUS);
	assign rd_line_status = access_end & ~pwrite & (paddr == ADDR_LINE_STATUS);

	assign pready = (s_q.bus == BUS_DONE);
	assign pslverr = (s_q.bus == BUS_DONE) & s_q.slverr;
	assign prdata = s_q.rdata;
	assign fifo_on_status = s_q.fifo_on;
	assign modem_drive = s_q.drive;

	////////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		s_d = s_q;

		case (s_q.bus)
			BUS_IDLE: begin
				if (access_start) begin
					s_d.bus = BUS_LATCH;
				end
			end
			BUS_LATCH: begin
				s_d.rdata = pwrite ? 32'h0000_0000 : read_value;
				s_d.slverr = ~addr_hit;
				s_d.bus = BUS_DONE;
			end
			BUS_DONE: begin
				s_d.bus = BUS_IDLE;
			end
			default: begin
				s_d.bus = BUS_IDLE;
			end
		endcase

		if (wr_ok) begin
			case (paddr)
				ADDR_INT_ENABLE: begin
					s_d.int_enable = pwdata[EV_W-1:0];
				end
				ADDR_IDENT_FCTL: begin
					s_d.fifo_on = pwdata[FC_FIFO_EN];
				end
				ADDR_MODEM_CONTROL: begin
					s_d.modem_control = pwdata[MC_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Clears come first so that an event in the same cycle still lands.
		if (wr_ok && paddr == ADDR_EVENT_CLEAR) begin
			s_d.ev_status = s_q.ev_status & ~pwdata[EV_W-1:0];
		end
		if (rd_modem_status) begin
			s_d.modem_flags = '0;
			s_d.ev_status[EV_MODEM] = 1'b0;
		end
		if (rd_line_status) begin
			s_d.line_err = '0;
			s_d.ev_status[EV_LINE] = 1'b0;
		end
		s_d.modem_flags = s_d.modem_flags | flag_set;
		s_d.line_err = s_d.line_err | line_err_set;
		s_d.ev_status = s_d.ev_status | ev_set;

		// In internal_loop_mode the modem outputs rest inactive.
		s_d.drive.dtr_n = s_d.modem_control[MC_LOOP] | ~s_d.modem_control[MC_DTR];
		s_d.drive.rts_n = s_d.modem_control[MC_LOOP] | ~s_d.modem_control[MC_RTS];
		s_d.drive.user_output_one = ~s_d.modem_control[MC_LOOP] & s_d.modem_control[MC_USER_OUTPUT_ONE];
		s_d.drive.user_output_two = ~s_d.modem_control[MC_LOOP] & s_d.modem_control[MC_USER_OUTPUT_TWO];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.bus <= BUS_IDLE;
			s_q.rdata <= '0;
			s_q.slverr <= 1'b0;
			s_q.int_enable <= INT_ENABLE_RST;
			s_q.fifo_on <= 1'b0;
			s_q.modem_control <= MODEM_CONTROL_RST;
			s_q.line_err <= '0;
			s_q.modem_flags <= '0;
			s_q.ev_status <= '0;
			s_q.drive <= 4'hC;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : uart_irq_modem_status

// ==== uart_irq_modem_status_chk.sv ====
module uart_irq_modem_status_chk
	import uart_irq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire modem_drive_t modem_drive,
	input wire logic fifo_on_status,
	input wire logic irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic mapped;
	logic rd_id;
	logic wr_mc;
	assign mapped = paddr inside {ADDR_INT_ENABLE, ADDR_IDENT_FCTL, ADDR_MODEM_CONTROL, ADDR_LINE_STATUS,
		ADDR_MODEM_STATUS, ADDR_EVENT_STATUS, ADDR_EVENT_CLEAR};
	assign rd_id = pready && !pwrite && paddr == ADDR_IDENT_FCTL;
	assign wr_mc = pready && pwrite && paddr == ADDR_MODEM_CONTROL;
	////////////////////////////////////////
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 !pready ##1 pready)
		else $error("answer not in third access cycle");
	a_ready_bus: assert property (pready |-> psel && penable)
		else $error("ready outside an access");
	a_ident_fifo: assert property (rd_id |-> prdata[7] == fifo_on_status)
		else $error("fifo bit wrong");
	a_ident_rsvd: assert property (rd_id |-> prdata[31:8] == 24'h0 && prdata[6:4] == 3'h0)
		else $error("reserved identification bits set");
	a_bad_addr: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_good_addr: assert property (pready && mapped |-> !pslverr)
		else $error("mapped access refused");
	a_clear_zero: assert property (pready && !pwrite && paddr == ADDR_EVENT_CLEAR |-> prdata == 32'h0)
		else $error("clear register not zero");
	a_drive_norm: assert property (wr_mc && !pwdata[MC_LOOP] |=> modem_drive == {~$past(pwdata[0]),
		~$past(pwdata[1]), $past(pwdata[2]), $past(pwdata[3])})
		else $error("modem outputs wrong");
	a_drive_loop: assert property (wr_mc && pwdata[MC_LOOP] |=> modem_drive == 4'hC)
		else $error("modem outputs active in loop");
	a_irq_off: assert property (pready && pwrite && paddr == ADDR_INT_ENABLE && pwdata[4:0] == 5'h0 |=> !irq)
		else $error("irq with all sources off");
endmodule : uart_irq_modem_status_chk

bind uart_irq_modem_status uart_irq_modem_status_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .modem_drive, .fifo_on_status, .irq);

// ==== modem_far_end.sv ====
module modem_far_end
	import uart_irq_pkg::*;
(
	input wire logic pclk,
	input wire logic [3:0] line_level,
	output modem_pins_t pins
);
	timeunit 1ns;
	timeprecision 100ps;
	// The far set drives its handshake lines low when asserted, changing just after an edge.
	initial begin
		pins = 4'hF;
		forever @(posedge pclk) pins <= ~line_level;
	end
endmodule : modem_far_end

// ==== uart_irq_modem_status_tb.sv ====
module uart_irq_modem_status_tb
	import uart_irq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr, fifo_on_status, irq;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdata, pw;
	logic [3:0] lvl = 4'h0, prev, nx, e, m;
	modem_pins_t modem_pins;
	modem_drive_t modem_drive;
	core_status_t core_status = '0;
	int mismatches = 0, n_compared = 0, seed = 32'h7E8B7F8B;
	logic [8:0] cs_tab [8] = '{9'h100, 9'h080, 9'h020, 9'h030, 9'h008, 9'h004, 9'h002, 9'h001};
	int ev_tab [8] = '{0, 0, 1, 4, 2, 2, 2, 2};
	logic [2:0] code_tab [8] = '{3'h2, 3'h6, 3'h1, 3'h4, 3'h3, 3'h3, 3'h3, 3'h3};
	always #12.5 pclk = ~pclk;
	uart_irq_modem_status u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .modem_pins, .modem_drive, .core_status, .fifo_on_status, .irq);
	modem_far_end u_far (.pclk, .line_level(lvl), .pins(modem_pins));
	////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			$display("wrong value %s: expected %h, seen %h", s, x, g);
			mismatches++;
		end
	endtask : chk
	// The answer is taken at the rising edge where pready is sampled high, or after 20 edges without it, and the bus then released.
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdata = prdata;
		rerr = pslverr;
		chk("pready", 1, pready);
		psel <= 0;
		penable <= 0;
	endtask : bus
	task stop_test;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		stop_test;
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		bus(0, ADDR_IDENT_FCTL, 0);
		chk("ident reset", IDENT_RST, rdata);
		bus(1, ADDR_IDENT_FCTL, 32'h1);
		bus(0, ADDR_IDENT_FCTL, 0);
		chk("ident fifo", 32'h81, rdata);
		chk("fifo out", 1, fifo_on_status);
		bus(0, 12'hFFC, 0);
		chk("slverr", 1, rerr);
		pw = $random(seed);
		bus(1, ADDR_INT_ENABLE, pw);
		bus(0, ADDR_INT_ENABLE, 0);
		chk("enable", {27'h0, pw[4:0]}, rdata);
		bus(1, ADDR_INT_ENABLE, 0);
		bus(1, ADDR_EVENT_CLEAR, 32'h1F);
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk) core_status <= cs_tab[i];
			bus(0, ADDR_EVENT_STATUS, 0);
			chk("event", 1, rdata[ev_tab[i]]);
			chk("masked irq", 0, irq);
			bus(1, ADDR_INT_ENABLE, 32'h1 << ev_tab[i]);
			bus(0, ADDR_IDENT_FCTL, 0);
			chk("ident", {24'h0, 4'h8, code_tab[i], 1'b0}, rdata);
			chk("irq on", 1, irq);
			@(posedge pclk) core_status <= '0;
			if (ev_tab[i] == EV_LINE) begin
				bus(0, ADDR_LINE_STATUS, 0);
				chk("line status", {27'h0, cs_tab[i][0], cs_tab[i][2], cs_tab[i][3], cs_tab[i][1], 1'b0}, rdata);
			end else begin
				bus(1, ADDR_EVENT_CLEAR, 32'h1 << ev_tab[i]);
			end
			@(negedge pclk);
			chk("irq cleared", 0, irq);
			bus(1, ADDR_EVENT_CLEAR, 32'h1F);
			bus(1, ADDR_INT_ENABLE, 0);
		end
		bus(1, ADDR_INT_ENABLE, 32'h8);
		bus(0, ADDR_MODEM_STATUS, 0);
		prev = lvl;
		for (int i = 0; i < 10; i++) begin
			nx = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($random(seed));
			e = {prev[3] ^ nx[3], prev[2] & ~nx[2], prev[1] ^ nx[1], prev[0] ^ nx[0]};
			@(posedge pclk) lvl <= nx;
			repeat (5) @(posedge pclk);
			@(negedge pclk);
			chk("modem irq", |e, irq);
			bus(0, ADDR_MODEM_STATUS, 0);
			chk("modem status", {24'h0, nx, e}, rdata);
			@(negedge pclk);
			chk("modem irq read", 0, irq);
			prev = nx;
		end
		for (int i = 0; i < 4; i++) begin
			m = 4'($random(seed));
			bus(1, ADDR_MODEM_CONTROL, {27'h0, 1'b1, m});
			@(negedge pclk);
			chk("loop drive", 4'hC, modem_drive);
			bus(0, ADDR_MODEM_STATUS, 0);
			chk("loop status", {m[3], m[2], m[0], m[1]}, rdata[7:4]);
			bus(1, ADDR_MODEM_CONTROL, {28'h0, m});
			@(negedge pclk);
			chk("drive", {~m[0], ~m[1], m[2], m[3]}, modem_drive);
			bus(0, ADDR_MODEM_STATUS, 0);
		end
		stop_test;
	end
endmodule : uart_irq_modem_status_tb
